// File: ssrp_params.svh
// Constants for the supply supervisor and serial pin block
`ifndef SSRP_PARAMS_SVH
`define SSRP_PARAMS_SVH
`define SSRP_CLK_MHZ 100
`define SSRP_RELEASE_MS 200
`define SSRP_RELEASE_CYCLES (`SSRP_RELEASE_MS * 1000 * `SSRP_CLK_MHZ)
`define SSRP_RESET_ACTIVE_LOW 1'b1
`define SSRP_TRIP_NATIVE 4'h0
`define SSRP_TRIP_WIDTH 4
`endif

// File: ssrp_pkg.sv
// Types for the supply supervisor and serial pin block
package ssrp_pkg;
  typedef enum logic [2:0] {
    SSRP_HOLD = 3'b001,
    SSRP_COUNT = 3'b010,
    SSRP_RUN = 3'b100
  } ssrp_sup_t;
  typedef enum logic [1:0] {
    SSRP_OFF = 2'b01,
    SSRP_ON = 2'b10
  } ssrp_power_t;
endpackage

// File: ssrp_sync.sv
// Two flip-flop synchroniser, one per bit
`timescale 1ns/1ns
module ssrp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      always_ff @(posedge clk) begin
        if (reset) begin
          stage1 <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          stage1 <= din[i];
          dout[i] <= stage1;
        end
      end
    end
  endgenerate
endmodule // ssrp_sync

// File: ssrp_supervisor.sv
// Supply supervisor reset output and serial port pin front end
`timescale 1ns/1ns
`include "ssrp_params.svh"
module ssrp_supervisor #(
  parameter int RELEASE_CYCLES = `SSRP_RELEASE_CYCLES,
  parameter bit RESET_ACTIVE_LOW = `SSRP_RESET_ACTIVE_LOW,
  parameter int TRIP_W = `SSRP_TRIP_WIDTH
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic supplyAbove1v,
  input wire logic supplyAboveTrip,
  input wire logic [TRIP_W-1:0] programTripLevel,
  input wire logic progHighOnClock,
  input wire logic progHighOnInput,
  input wire logic nvWriteBusy,
  input wire logic readCycle,
  input wire logic txBit,
  input wire logic guardLockBit,
  input wire logic writeGuardN,
  input wire logic chipSelectN,
  input wire logic serialClock,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  output logic rxBit,
  output logic rxValid,
  output logic portEnabled,
  output logic standby,
  output logic settingsLocked,
  output logic [TRIP_W-1:0] supplyTripLevel,
  output logic resetOut,
  output logic resetOutEn
);
  localparam int CNT_W = $clog2(RELEASE_CYCLES + 1);

  // Link domain: chip select high acts as that domain's reset
  logic linkRxBit;
  logic linkRxToggle;
  logic linkOut;
  always_ff @(posedge serialClock or posedge chipSelectN) begin
    if (chipSelectN) begin
      linkRxBit <= 1'b0;
      linkRxToggle <= 1'b0;
    end else begin
      linkRxBit <= serialIn;
      linkRxToggle <= ~linkRxToggle;
    end
  end
  // Reads shift on the falling edge
  always_ff @(negedge serialClock or posedge chipSelectN) begin
    if (chipSelectN) begin
      linkOut <= 1'b0;
    end else begin
      linkOut <= txBit;
    end
  end
  assign serialOut = linkOut;
  // Float output while deselected or outside a read
  assign serialOutEn = ~chipSelectN & readCycle;

  // Bring pins and link signals into the system domain
  logic [5:0] syncIn;
  logic [5:0] syncOut;
  assign syncIn = {supplyAbove1v, supplyAboveTrip, chipSelectN,
                   linkRxToggle, linkRxBit, writeGuardN};
  ssrp_sync #(.WIDTH(6)) u_sync (
    .clk(mclk),
    .reset(reset),
    .din(syncIn),
    .dout(syncOut)
  );
  logic above1v, aboveTrip, csN, rxTog, rxData, guardN;
  assign {above1v, aboveTrip, csN, rxTog, rxData, guardN} = syncOut;

  // Power-up arm: needs one chip select falling edge
  logic csPrev;
  logic armed;
  logic rxTogPrev;
  ssrp_pkg::ssrp_power_t power;
  always_ff @(posedge mclk) begin
    if (reset) begin
      csPrev <= 1'b1;
      armed <= 1'b0;
      power <= ssrp_pkg::SSRP_OFF;
    end else if (clkEn) begin
      csPrev <= csN;
      case (power)
        ssrp_pkg::SSRP_OFF: begin
          armed <= 1'b0;
          if (above1v) begin
            power <= ssrp_pkg::SSRP_ON;
          end
        end
        ssrp_pkg::SSRP_ON: begin
          if (!above1v) begin
            power <= ssrp_pkg::SSRP_OFF;
          end else if (csPrev && !csN) begin
            armed <= 1'b1;
          end
        end
        default: power <= ssrp_pkg::SSRP_OFF;
      endcase
    end
  end
  assign portEnabled = armed & ~csN;
  assign standby = csN & ~nvWriteBusy;

  // Received bit passes over as a toggle event
  always_ff @(posedge mclk) begin
    if (reset) begin
      rxTogPrev <= 1'b0;
      rxBit <= 1'b0;
      rxValid <= 1'b0;
    end else if (clkEn) begin
      rxTogPrev <= rxTog;
      rxValid <= (rxTog != rxTogPrev) & portEnabled;
      rxBit <= rxData;
    end
  end

  // Locked when guard pin low and lock bit set
  always_ff @(posedge mclk) begin
    if (reset) begin
      settingsLocked <= 1'b0;
    end else if (clkEn) begin
      settingsLocked <= guardLockBit & ~guardN;
    end
  end

  // Trip level programming, only while deselected and guard high
  always_ff @(posedge mclk) begin
    if (reset) begin
      supplyTripLevel <= `SSRP_TRIP_NATIVE;
    end else if (clkEn && progHighOnInput && guardN && csN && !csPrev) begin
      if (progHighOnClock) begin
        // Set only raises; lowering needs the native step first
        if (programTripLevel > supplyTripLevel) begin
          supplyTripLevel <= programTripLevel;
        end
      end else begin
        supplyTripLevel <= `SSRP_TRIP_NATIVE;
      end
    end
  end

  // Supervisor: hold, count, run
  ssrp_pkg::ssrp_sup_t sup;
  logic [CNT_W-1:0] delayCnt;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sup <= ssrp_pkg::SSRP_HOLD;
      delayCnt <= '0;
    end else if (clkEn) begin
      case (sup)
        ssrp_pkg::SSRP_HOLD: begin
          delayCnt <= '0;
          if (aboveTrip) begin
            sup <= ssrp_pkg::SSRP_COUNT;
          end
        end
        ssrp_pkg::SSRP_COUNT: begin
          if (!aboveTrip) begin
            sup <= ssrp_pkg::SSRP_HOLD;
          end else if (delayCnt == CNT_W'(RELEASE_CYCLES - 1)) begin
            sup <= ssrp_pkg::SSRP_RUN;
          end else begin
            delayCnt <= delayCnt + 1'b1;
          end
        end
        ssrp_pkg::SSRP_RUN: begin
          if (!aboveTrip) begin
            sup <= ssrp_pkg::SSRP_HOLD;
          end
        end
        default: sup <= ssrp_pkg::SSRP_HOLD;
      endcase
    end
  end

  // Open drain: enable means pulling low
  logic resetActive;
  assign resetActive = (sup != ssrp_pkg::SSRP_RUN);
  always_ff @(posedge mclk) begin
    if (reset) begin
      resetOutEn <= RESET_ACTIVE_LOW;
    end else if (clkEn) begin
      resetOutEn <= RESET_ACTIVE_LOW ? resetActive : ~resetActive;
    end
  end
  assign resetOut = 1'b0;

  a_release_delay: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && sup == ssrp_pkg::SSRP_COUNT && !aboveTrip)
      |=> sup == ssrp_pkg::SSRP_HOLD)
    else $error("Dip did not restart release delay");
  a_brownout_reset: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && !aboveTrip) |=> ##1 (resetOutEn == RESET_ACTIVE_LOW))
    else $error("Reset not asserted after brownout");
  a_arm_on_fall: assert property (@(posedge mclk) disable iff (reset)
    $rose(armed) |-> $past(csPrev) && !$past(csN))
    else $error("Port armed without chip select fall");
  a_lock_guard: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && guardN) |=> !settingsLocked)
    else $error("Settings locked with guard pin high");
  a_trip_raise: assert property (@(posedge mclk) disable iff (reset)
    (progHighOnClock && !$changed(progHighOnClock) && $changed(supplyTripLevel))
      |-> supplyTripLevel > $past(supplyTripLevel))
    else $error("Set procedure lowered trip level");
  a_standby_mode: assert property (@(posedge mclk) disable iff (reset)
    nvWriteBusy |-> !standby)
    else $error("Standby during nonvolatile write");
endmodule // ssrp_supervisor

// File: ssrp_host_model.sv
// Host side model: chip select, serial clock and trip programming
`timescale 1ns/1ns
module ssrp_host_model (
  output logic csN,
  output logic sclk,
  output logic sin,
  output logic pClk,
  output logic pIn,
  output logic [3:0] lvl
);
  // Select starts low so the first frame comes with no falling edge
  initial begin
    {csN, sclk, sin, pClk, pIn, lvl} = 9'h000;
  end
  // Clock idles low between bits, data set up half a period early
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sin = b[i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    sin = ~sin;
  endtask
  task automatic cs(input logic v);
    #17 csN = v;
    #60;
  endtask
  // Raise puts high voltage on clock and input; native on input only
  task automatic prog(input logic raise, input logic [3:0] l);
    lvl = l;
    sclk = ~raise;
    pClk = raise;
    pIn = 1'b1;
    cs(1'b0);
    cs(1'b1);
    {pClk, pIn, sclk} = 3'h0;
  endtask
endmodule // ssrp_host_model

// File: ssrp_supervisor_tb.sv
// Self-checking bench for the supervisor and serial pin block
`timescale 1ns/1ns
module ssrp_supervisor_tb;
  localparam int RC = 10;
  logic mclk, reset, above1v, aboveTrip, nvBusy, rdCyc, txBit, lockBit;
  logic wgN, csN, sclk, sin, pClk, pIn, serialOut, serialOutEn, rxBit;
  logic rxValid, portEnabled, standby, settingsLocked, resetOut, resetOutEn;
  logic mon, clkEn;
  logic [3:0] lvl, trip;
  logic [7:0] b;
  logic [3:0] lvls[4] = '{4'h5, 4'h3, 4'h0, 4'h3};
  logic [3:0] exps[4] = '{4'h5, 4'h5, 4'h0, 4'h3};
  logic q[$];
  int miscompares, check_count, seed;
  ssrp_host_model u_host (.csN(csN), .sclk(sclk), .sin(sin), .pClk(pClk),
    .pIn(pIn), .lvl(lvl));
  ssrp_supervisor #(.RELEASE_CYCLES(RC)) u_dut (.mclk(mclk), .reset(reset),
    .clkEn(clkEn), .supplyAbove1v(above1v), .supplyAboveTrip(aboveTrip),
    .programTripLevel(lvl), .progHighOnClock(pClk), .progHighOnInput(pIn),
    .nvWriteBusy(nvBusy), .readCycle(rdCyc), .txBit(txBit),
    .guardLockBit(lockBit), .writeGuardN(wgN), .chipSelectN(csN),
    .serialClock(sclk), .serialIn(sin), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .rxBit(rxBit), .rxValid(rxValid),
    .portEnabled(portEnabled), .standby(standby),
    .settingsLocked(settingsLocked), .supplyTripLevel(trip),
    .resetOut(resetOut), .resetOutEn(resetOutEn));
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // A received bit with nothing noted is itself a mismatch
  always @(posedge mclk) begin
    if (mon && rxValid !== 1'b0) begin
      if (q.size() == 0)
        chk("rxValid", 1'b0, rxValid);
      else
        chk("rxBit", q.pop_front(), rxBit);
    end
  end
  initial begin
    #100000;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    seed = 32'h99d330ee;
    {reset, above1v, aboveTrip, nvBusy, rdCyc, txBit, lockBit, mon} = 8'hc0;
    wgN = 1'b1;
    clkEn = 1'b1;
    miscompares = 0;
    check_count = 0;
    cyc(12);
    reset = 1'b0;
    mon = 1'b1;
    cyc(3);
    chk("resetOutEn", 1'b1, resetOutEn);
    chk("resetOut", 1'b0, resetOut);
    chk("trip", 4'h0, trip);
    u_host.send(8'ha5);
    cyc(6);
    chk("portEnabled", 1'b0, portEnabled);
    chk("standby", 1'b0, standby);
    rdCyc = 1'b1;
    u_host.cs(1'b1);
    cyc(3);
    chk("standby", 1'b1, standby);
    chk("serialOutEn", 1'b0, serialOutEn);
    nvBusy = 1'b1;
    cyc(2);
    chk("standby", 1'b0, standby);
    nvBusy = 1'b0;
    for (int k = 0; k < 3; k++) begin
      cyc(1);
      b = 8'($random(seed));
      txBit = b[0];
      u_host.cs(1'b0);
      for (int i = 7; i >= 0; i--) q.push_back(b[i]);
      u_host.send(b);
      cyc(6);
      chk("serialOut", txBit, serialOut);
      chk("serialOutEn", 1'b1, serialOutEn);
      chk("portEnabled", 1'b1, portEnabled);
      u_host.cs(1'b1);
      chk("serialOutEn", 1'b0, serialOutEn);
    end
    chk("rxPending", 1'b0, q.size() != 0);
    // Power cycle with select already low: no fall, so no bits taken
    above1v = 1'b0;
    cyc(4);
    u_host.cs(1'b0);
    cyc(2);
    above1v = 1'b1;
    cyc(4);
    u_host.send(b);
    cyc(6);
    chk("portEnabled", 1'b0, portEnabled);
    u_host.cs(1'b1);
    u_host.cs(1'b0);
    cyc(3);
    chk("portEnabled", 1'b1, portEnabled);
    u_host.cs(1'b1);
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      {lockBit, wgN} = i[1:0];
      cyc(4);
      chk("settingsLocked", i == 2, settingsLocked);
    end
    wgN = 1'b1;
    foreach (lvls[j]) begin
      u_host.prog(j != 2, lvls[j]);
      cyc(6);
      chk("trip", exps[j], trip);
    end
    aboveTrip = 1'b1;
    cyc(6);
    aboveTrip = 1'b0;
    cyc(2);
    aboveTrip = 1'b1;
    cyc(RC + 3);
    chk("resetOutEn", 1'b1, resetOutEn);
    cyc(2);
    chk("resetOutEn", 1'b0, resetOutEn);
    // Clock enable low must freeze the supervisor through a brownout
    clkEn = 1'b0;
    aboveTrip = 1'b0;
    cyc(6);
    chk("resetOutEn", 1'b0, resetOutEn);
    clkEn = 1'b1;
    cyc(6);
    chk("resetOutEn", 1'b1, resetOutEn);
    tally_and_finish;
  end
endmodule // ssrp_supervisor_tb
